//--- rtl/cbt_pkg.sv
`default_nettype none

package cbt_pkg;

	// ----------------------------------------
	// clock and timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int WAKE_FILT_NS = 50;
	localparam int WAKE_FILT_CYC = (WAKE_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [2:0] WAKE_FILT_CNT = 3'(WAKE_FILT_CYC);
	localparam logic [3:0] INFO_PROCESSING_TIME = 4'h2;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] CFG2_OFFSET = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;
	localparam logic [15:0] CFG2_RESET = 16'h0000;
	localparam logic [15:0] CFG2_WMASK = 16'h47FF;
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int WAKE_SEL_BIT = 14;
	localparam int PH2_LSB = 8;
	localparam int PH2_FREE_BIT = 7;
	localparam int TRIPLE_BIT = 6;
	localparam int PH1_LSB = 3;
	localparam int PROP_LSB = 0;

	typedef enum logic [1:0]
	{
		CBT_SYNC = 2'b00,
		CBT_PROP = 2'b01,
		CBT_PH1 = 2'b11,
		CBT_PH2 = 2'b10
	} cbt_seg_t;

endpackage

`default_nettype wire

//--- rtl/cbt_line_sampler.sv
`default_nettype none

module cbt_line_sampler
	import cbt_pkg::*;
(
	// clock, reset, enable
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	// bus line and control
	input wire logic can_rx,
	input wire logic filt_en,
	// results
	output var logic line,
	output var logic maj_bit,
	output var logic wake_event
);

	logic sync1;
	logic [1:0] hist;
	logic [2:0] filt_cnt;
	logic filt_line;
	logic prev_sel;
	logic [1:0] next_hist;
	logic [2:0] next_filt_cnt;
	logic next_filt_line;
	logic sel_line;
	logic next_wake;

	// ----------------------------------------
	// filter and majority
	// ----------------------------------------
	always_comb
	begin
		next_hist = {hist[0], line};
		// majority stays combinational so its three quanta end where the single sample is taken
		maj_bit = (hist[0] & hist[1]) | (hist[0] & line) | (hist[1] & line);
		// a dominant level must stand for several cycles, so bus glitches cannot wake us
		next_filt_cnt = line ? 3'h0 : filt_cnt;
		if (!line && filt_cnt != WAKE_FILT_CNT)
			next_filt_cnt = filt_cnt + 3'h1;
		next_filt_line = filt_line;
		if (line)
			next_filt_line = 1'b1;
		else if (filt_cnt == WAKE_FILT_CNT)
			next_filt_line = 1'b0;
		sel_line = filt_en ? filt_line : line;
		next_wake = prev_sel & ~sel_line;
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			sync1 <= 1'b1;
			line <= 1'b1;
			hist <= 2'h3;
			filt_cnt <= 3'h0;
			filt_line <= 1'b1;
			prev_sel <= 1'b1;
			wake_event <= 1'b0;
		end
		else if (ce)
		begin
			sync1 <= can_rx;
			line <= sync1;
			hist <= next_hist;
			filt_cnt <= next_filt_cnt;
			filt_line <= next_filt_line;
			prev_sel <= sel_line;
			wake_event <= next_wake;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	raw_wake_a: assert property (@(posedge core_clk) disable iff (rst)
		(ce && !filt_en && prev_sel && !line) |=> wake_event)
		else $error("unfiltered falling line did not wake");

	filt_wake_a: assert property (@(posedge core_clk) disable iff (rst)
		(ce && filt_en && filt_line && !line) |=> !wake_event)
		else $error("filtered line woke on first dominant cycle");

endmodule

`default_nettype wire

//--- rtl/cbt_top.sv
// The AHB-Lite interface to the registers and the address map were left to the implementer.
`default_nettype none

module cbt_top
	import cbt_pkg::*;
(
	// clock, reset, enable
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// can bus line
	input wire logic can_rx,
	// bit timing results
	output logic bit_start,
	output logic sample_pulse,
	output logic sampled_bit,
	output logic wake_event
);

	logic [15:0] cfg;
	logic [15:0] next_cfg;
	logic wr_pend;
	logic [7:0] wr_addr;
	logic next_wr_pend;
	logic [7:0] next_wr_addr;
	logic [31:0] next_hrdata;
	logic addr_ok;
	cbt_seg_t state;
	cbt_seg_t next_state;
	logic [2:0] cnt;
	logic [2:0] next_cnt;
	logic [3:0] seg_len;
	logic [3:0] ph1_len;
	logic seg_last;
	logic next_bit_start;
	logic next_sample;
	logic next_sampled;
	logic line;
	logic maj_bit;

	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	// the slave never stalls and never errors, so hreadyout and hresp are constant flops
	always_comb
	begin
		addr_ok = hsel && htrans[1] && hready && hsize == HSIZE_WORD;
		next_wr_pend = addr_ok && hwrite;
		next_wr_addr = haddr[7:0];
		next_cfg = cfg;
		if (wr_pend && wr_addr == CFG2_OFFSET)
			next_cfg = hwdata[15:0] & CFG2_WMASK;
		// forward next_cfg so a read right after a write sees the new value
		next_hrdata = hrdata;
		if (addr_ok && !hwrite)
		begin
			next_hrdata = 32'h0;
			if (haddr[7:0] == CFG2_OFFSET)
				next_hrdata = {16'h0, next_cfg};
			else if (haddr[7:0] == STATUS_OFFSET)
				next_hrdata = {29'h0, sampled_bit, state};
		end
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			cfg <= CFG2_RESET;
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			hrdata <= 32'h0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			cfg <= next_cfg;
			wr_pend <= next_wr_pend;
			wr_addr <= next_wr_addr;
			hrdata <= next_hrdata;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// ----------------------------------------
	// line sampling and wake filter
	// ----------------------------------------
	cbt_line_sampler u_sampler
	(
		.core_clk(core_clk),
		.rst(rst),
		.ce(ce),
		.can_rx(can_rx),
		.filt_en(cfg[WAKE_SEL_BIT]),
		.line(line),
		.maj_bit(maj_bit),
		.wake_event(wake_event)
	);

	// ----------------------------------------
	// bit time sequencer
	// ----------------------------------------
	// one quantum per enabled clock; ce is the quantum tick
	always_comb
	begin
		ph1_len = {1'b0, cfg[PH1_LSB +: 3]} + 4'h1;
		unique case (state)
			CBT_SYNC: seg_len = 4'h1;
			CBT_PROP: seg_len = {1'b0, cfg[PROP_LSB +: 3]} + 4'h1;
			CBT_PH1: seg_len = ph1_len;
			CBT_PH2:
			begin
				if (cfg[PH2_FREE_BIT])
					seg_len = {1'b0, cfg[PH2_LSB +: 3]} + 4'h1;
				else if (ph1_len > INFO_PROCESSING_TIME)
					seg_len = ph1_len;
				else
					seg_len = INFO_PROCESSING_TIME;
			end
		endcase
		seg_last = {1'b0, cnt} == seg_len - 4'h1;
		next_cnt = seg_last ? 3'h0 : cnt + 3'h1;
		next_state = state;
		if (seg_last)
		begin
			unique case (state)
				CBT_SYNC: next_state = CBT_PROP;
				CBT_PROP: next_state = CBT_PH1;
				CBT_PH1: next_state = CBT_PH2;
				CBT_PH2: next_state = CBT_SYNC;
			endcase
		end
		next_bit_start = seg_last && state == CBT_PH2;
		next_sample = seg_last && state == CBT_PH1;
		next_sampled = sampled_bit;
		if (next_sample)
			next_sampled = cfg[TRIPLE_BIT] ? maj_bit : line;
	end

	// pulses hold while ce is low; consumers qualify them with ce
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			state <= CBT_SYNC;
			cnt <= 3'h0;
			bit_start <= 1'b0;
			sample_pulse <= 1'b0;
			sampled_bit <= 1'b1;
		end
		else if (ce)
		begin
			state <= next_state;
			cnt <= next_cnt;
			bit_start <= next_bit_start;
			sample_pulse <= next_sample;
			sampled_bit <= next_sampled;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	logic [3:0] run;
	logic [3:0] exp_ph2;
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			run <= 4'h0;
		else if (ce)
			run <= (next_state != state) ? 4'h0 : run + 4'h1;
	end
	assign exp_ph2 = cfg[PH2_FREE_BIT] ? 4'(cfg[10:8]) + 4'h1 :
		((4'(cfg[5:3]) + 4'h1 > INFO_PROCESSING_TIME) ? 4'(cfg[5:3]) + 4'h1 :
		INFO_PROCESSING_TIME);

	ph2_free_a: assert property ((ce && state == CBT_PH2 && cfg[7]
		&& run == 4'(cfg[10:8])) |=> state == CBT_SYNC)
		else $error("free phase 2 length wrong");

	ph2_derived_a: assert property ((ce && state == CBT_PH2 && !cfg[7]
		&& run == exp_ph2 - 4'h1) |=> state == CBT_SYNC)
		else $error("derived phase 2 length wrong");

	ph1_len_a: assert property ((ce && state == CBT_PH1 && run == 4'(cfg[5:3]))
		|=> state == CBT_PH2 && sample_pulse)
		else $error("phase 1 length wrong");

	prop_len_a: assert property ((ce && state == CBT_PROP && run < 4'(cfg[2:0]))
		|=> state == CBT_PROP)
		else $error("propagation segment ended early");

	seg_order_a: assert property ((ce && state == CBT_SYNC) |=> state == CBT_PROP)
		else $error("sync segment not one quantum");

	triple_samp_a: assert property ((ce && next_sample && cfg[6])
		|=> sampled_bit == $past(maj_bit))
		else $error("triple sample not majority");

	single_samp_a: assert property ((ce && next_sample && !cfg[6])
		|=> sampled_bit == $past(line))
		else $error("single sample wrong");

	cfg_write_a: assert property ((wr_pend && wr_addr == CFG2_OFFSET)
		|=> cfg[14] == $past(hwdata[14]) && cfg[15] == 1'b0)
		else $error("config write lost");

	bit_cyc_c: cover property (ce && bit_start);
	triple_c: cover property (ce && sample_pulse && cfg[6]);
	derived_c: cover property (ce && state == CBT_PH2 && !cfg[7] && run == 4'h1);
	wake_c: cover property (wake_event && cfg[14]);

endmodule

`default_nettype wire

//--- sim/cbt_bus_node.sv
`default_nettype none

module cbt_bus_node
(
	// clock and request
	input wire logic core_clk,
	input wire logic go,
	input wire logic [7:0] low_len,
	// bus line
	output logic can_rx
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] left = 8'h00;
	// recessive between frames: the bus pull-up holds the line high
	assign can_rx = (left == 8'h00);
	// dominant for low_len cycles, so glitches and long lows can both be made
	always @(posedge core_clk)
		if (go)
			left <= low_len;
		else if (left != 8'h00)
			left <= left - 8'h01;
endmodule

`default_nettype wire

//--- sim/can_bit_timing_config2_bench.sv
`default_nettype none

module can_bit_timing_config2_bench
	import cbt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic go = 1'b0;
	logic ce = 1'b1;
	logic [2:0] hsize = HSIZE_WORD;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [7:0] low_len = 8'h00;
	logic [31:0] hrdata;
	logic hreadyout, hresp, bit_start, sample_pulse, sampled_bit, wake_event, can_rx;
	int fail_count = 0;
	int n_checks = 0;

	initial
		forever #5 core_clk = ~core_clk;

	// ce stays high outside the freeze scenario, so one cycle is one quantum
	cbt_top cbt_top_inst (.core_clk(core_clk), .rst(rst), .ce(ce), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .can_rx(can_rx), .bit_start(bit_start),
		.sample_pulse(sample_pulse), .sampled_bit(sampled_bit), .wake_event(wake_event));
	cbt_bus_node cbt_bus_node_inst (.core_clk(core_clk), .go(go), .low_len(low_len),
		.can_rx(can_rx));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic end_sim;
		if (fail_count == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic hang;
		fail_count++;
		end_sim();
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic wait_rdy;
		int i;
		i = 0;
		do
		begin
			@(posedge core_clk);
			i++;
			if (i > 50)
				hang();
		end
		while (hreadyout !== 1'b1);
	endtask

	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] q);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		q = hrdata;
		check({31'h0, hresp}, 32'h0);
	endtask

	task automatic to_bit;
		int i;
		i = 0;
		do
		begin
			@(posedge core_clk);
			i++;
			if (i > 60)
				hang();
		end
		while (bit_start !== 1'b1);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic regs;
		logic [31:0] q;
		bus(1'b0, 32'h0, 32'h0, q);
		check(q, {16'h0, CFG2_RESET});
		bus(1'b1, 32'h0, 32'hFFFFFFFF, q);
		bus(1'b0, 32'h0, 32'h0, q);
		check(q, 32'h000047FF);
		// a byte-sized write must not touch the word register
		hsize <= 3'h0;
		bus(1'b1, 32'h0, 32'h0, q);
		hsize <= HSIZE_WORD;
		bus(1'b0, 32'h0, 32'h0, q);
		check(q, 32'h000047FF);
		bus(1'b0, 32'h8, 32'h0, q);
		check(q, 32'h0);
	endtask

	// with ce low the segment state must not move, yet the bus still answers
	task automatic freeze;
		logic [31:0] q1;
		logic [31:0] q2;
		logic [31:0] q;
		ce <= 1'b0;
		bus(1'b0, {24'h0, STATUS_OFFSET}, 32'h0, q1);
		repeat (6) @(posedge core_clk);
		bus(1'b0, {24'h0, STATUS_OFFSET}, 32'h0, q2);
		check(q2, q1);
		bus(1'b1, 32'h0, 32'h0392, q);
		bus(1'b0, 32'h0, 32'h0, q);
		check(q, 32'h00000392);
		ce <= 1'b1;
	endtask

	// dominant pulse placed just before the sample point of a 25 quantum bit
	task automatic samp(input logic [31:0] cfg, input int lead, input logic [7:0] low,
		input logic want);
		logic [31:0] q;
		bus(1'b1, 32'h0, cfg, q);
		to_bit();
		to_bit();
		repeat (lead) @(posedge core_clk);
		low_len <= low;
		go <= 1'b1;
		@(posedge core_clk);
		go <= 1'b0;
		repeat (17 - lead) @(posedge core_clk);
		check({31'h0, sampled_bit}, {31'h0, want});
	endtask

	// skip the bit in which the write landed and one more, then time one whole bit
	task automatic timing(input logic [31:0] cfg, input int len, input int sp);
		int n;
		int s;
		logic [31:0] q;
		bus(1'b1, 32'h0, cfg, q);
		to_bit();
		to_bit();
		n = 0;
		s = 0;
		do
		begin
			@(posedge core_clk);
			n++;
			if (sample_pulse === 1'b1)
				s = n;
		end
		while (bit_start !== 1'b1 && n < 40);
		check(32'(n), 32'(len));
		check(32'(s), 32'(sp));
	endtask

	task automatic wake(input logic [31:0] cfg, input logic [7:0] low, input logic want);
		logic [31:0] q;
		logic seen;
		bus(1'b1, 32'h0, cfg, q);
		seen = 1'b0;
		low_len <= low;
		go <= 1'b1;
		@(posedge core_clk);
		go <= 1'b0;
		repeat (30)
		begin
			@(posedge core_clk);
			if (wake_event === 1'b1)
				seen = 1'b1;
		end
		check({31'h0, seen}, {31'h0, want});
	endtask

	initial
	begin
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		regs();
		timing(32'h0080, 4, 3);
		timing(32'h07FF, 25, 17);
		timing(32'h0392, 11, 7);
		timing(32'h0028, 14, 8);
		timing(32'h0000, 3 + int'(INFO_PROCESSING_TIME), 3);
		freeze();
		samp(32'h07BF, 12, 8'h01, 1'b0);
		samp(32'h07FF, 12, 8'h01, 1'b1);
		samp(32'h07FF, 10, 8'h03, 1'b0);
		wake(32'h0, 8'h03, 1'b1);
		wake(32'h4000, 8'h03, 1'b0);
		wake(32'h4000, 8'h0C, 1'b1);
		end_sim();
	end
endmodule

`default_nettype wire
